// *** csc_clkout_divider.v ***
// Divides the selected source tick train for the clock output pin.
// Assumes one tick pulse per source clock cycle, synchronous to clock_i.
`include "csc_defs.vh"

module csc_clkout_divider (
  // Clock and reset.
  input  wire       clock_i,
  input  wire       rst_n_i,
  // Source and division.
  input  wire       tick_i,
  input  wire [3:0] div_sel_i,
  // Divided clock level.
  output reg        clk_level_o
);

  reg  [7:0] cnt_q;
  wire [3:0] sel_cap;
  wire [7:0] mask;

  // Reserved division codes act as the largest division.
  assign sel_cap = (div_sel_i > `CSC_DIV_MAX) ? `CSC_DIV_MAX : div_sel_i;
  assign mask    = (sel_cap == `CSC_DIV_MAX) ? `CSC_MASK_FULL : (`CSC_MASK_FULL >> (`CSC_DIV_MAX - sel_cap));

  // Toggle the level once every two to the power of the selection ticks.
  always @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_q       <= 8'h00;
      clk_level_o <= 1'b0;
    end else if (tick_i) begin
      if (cnt_q >= mask) begin
        cnt_q       <= 8'h00;
        clk_level_o <= ~clk_level_o;
      end else begin
        cnt_q <= cnt_q + 8'h01;
      end
    end
  end

endmodule

// *** csc_clock_startup_ctrl.v ***
// Clock source selection, start-up timing, RC trim register and clock output.
// Assumes static fuse inputs, oscillator ticks synchronous to clock_i and an
// Avalon-MM master that holds each request until waitrequest falls.
//
// Overview of operation
// - Source codes 0110 and 0111 select the low-frequency watch crystal.
// - Crystal reset delay is 14 cycles plus 0, 4.1 ms or 65 ms; 11 reserved.
// - Crystal wake from sleep takes 1K cycles for 0110, 32K for 0111.
// - Source code 0010 selects the calibrated internal 8 MHz RC oscillator.
// - Every chip reset loads the factory calibration byte into the trim register.
// - RC wake takes 6 cycles; reset delay follows start-up codes 00, 01, 10.
// - The watchdog oscillator still times reset time-out when RC clocks the chip.
// - Software may write the 8-bit trim register any time, retuning the oscillator.
// - Top trim bit picks one of two overlapping ranges, low or high.
// - Lower seven trim bits tune frequency monotonically within the range.
// - The RC oscillator times non-volatile memory writes.
// - Source code 0000 takes the clock from the external clock pin.
// - External clock wake takes 6 cycles; reset delay follows start-up codes.
// - Programmed clock-output fuse drives the system clock on the output pin.
// - With prescaling active the output pin carries the divided clock.
// - The timer oscillator works only while the RC oscillator is the source.
// - The async external clock select makes the timer pin take a clock.
// - Fuse bits read one when unprogrammed and zero when programmed.
// - Real-time reset delay counts 0, 4,096 or 65,536 watchdog oscillator cycles.
`include "csc_defs.vh"

module csc_clock_startup_ctrl #(
  parameter [16:0] WDT_LONG_CYC     = 17'h10000,
  parameter [16:0] LF_SLOW_WAKE_CYC = 17'h08000
) (
  // Clock and reset.
  input  wire        clock_i,
  input  wire        rst_n_i,
  // Fuses, zero means programmed.
  input  wire [3:0]  clock_source_select_fuses_i,
  input  wire [1:0]  startup_time_fuses_i,
  input  wire        clock_output_fuse_i,
  input  wire [7:0]  calibration_byte_i,
  // Oscillator ticks, one pulse per source cycle.
  input  wire        lf_tick_i,
  input  wire        rc_tick_i,
  input  wire        ext_tick_i,
  input  wire        wdt_tick_i,
  // Power management.
  input  wire        wake_i,
  input  wire [3:0]  prescale_sel_i,
  // Timer oscillator requests.
  input  wire        timer_osc_request_i,
  input  wire        async_external_clock_select_i,
  // Normal function of the clock output pin.
  input  wire        gpio_out_i,
  input  wire        gpio_oe_n_i,
  // Avalon-MM slave.
  input  wire [1:0]  avs_address_i,
  input  wire        avs_read_i,
  input  wire        avs_write_i,
  input  wire [31:0] avs_writedata_i,
  input  wire [3:0]  avs_byteenable_i,
  output reg  [31:0] avs_readdata_o,
  output wire        avs_waitrequest_o,
  // Clock tree and oscillator control.
  output reg         cpu_clock_run_o,
  output reg  [1:0]  clock_source_o,
  output reg  [7:0]  rc_trim_register_o,
  output reg         trim_range_bit_o,
  output reg  [6:0]  trim_step_field_o,
  output reg         nvm_write_tick_o,
  // Timer oscillator control.
  output reg         timer_osc_enable_o,
  output reg         timer_osc_ext_clock_o,
  // Clock output pin.
  output wire        clock_output_pin_o,
  output wire        clock_output_pin_oe_n_o
);

  ////////////////////////////////////////////////////////////////////////////////
  // Start-up states, one-hot.
  localparam [6:0] ST_LOAD  = 7'h01;
  localparam [6:0] ST_WDT   = 7'h02;
  localparam [6:0] ST_CK14  = 7'h04;
  localparam [6:0] ST_RUN   = 7'h08;
  localparam [6:0] ST_SLEEP = 7'h10;
  localparam [6:0] ST_WAKE  = 7'h20;
  localparam [6:0] ST_FAULT = 7'h40;

  reg  [6:0]             state_q;
  reg  [6:0]             state_d;
  reg  [3:0]             sel_q;
  reg  [1:0]             sut_q;
  reg  [7:0]             trim_q;
  reg                    fault_q;
  reg                    ack_q;
  reg                    src_tick;
  reg  [1:0]             src_code;
  reg                    cfg_ok;
  reg  [`CSC_CNT_W-1:0]  wdt_load;
  reg  [`CSC_CNT_W-1:0]  wake_load;
  wire [`CSC_CNT_W-1:0]  ck_load;
  wire                   wdt_done;
  wire                   ck_done;
  wire                   load_wdt;
  wire                   load_ck;
  wire                   bus_req;
  wire                   wr_take;
  wire                   sleep_req;
  wire                   rc_selected;
  wire                   clk_div_level;
  wire [31:0]            status_word;
  wire [3:0]             sel_now;
  wire [1:0]             sut_now;

  ////////////////////////////////////////////////////////////////////////////////
  // The load cycle decodes the live fuses, because the latches only settle at its end.
  // Without this the first decision would see the reset codes and always fault.
  assign sel_now = (state_q == ST_LOAD) ? clock_source_select_fuses_i : sel_q;
  assign sut_now = (state_q == ST_LOAD) ? startup_time_fuses_i : sut_q;

  // Source decode; codes outside the four supported source codes give no tick.
  always @* begin
    src_tick = 1'b0;
    src_code = `CSC_SRC_NONE;
    case (sel_now)
      `CSC_SEL_LF_FAST, `CSC_SEL_LF_SLOW: begin
        src_tick = lf_tick_i;
        src_code = `CSC_SRC_LF;
      end
      `CSC_SEL_RC: begin
        src_tick = rc_tick_i;
        src_code = `CSC_SRC_RC;
      end
      `CSC_SEL_EXT: begin
        src_tick = ext_tick_i;
        src_code = `CSC_SRC_EXT;
      end
      default: begin
        src_tick = 1'b0;
        src_code = `CSC_SRC_NONE;
      end
    endcase
  end

  // Reset delay in watchdog cycles and wake count in source cycles.
  always @* begin
    cfg_ok    = (src_code != `CSC_SRC_NONE) && (sut_now != `CSC_SUT_RSVD);
    wdt_load  = `CSC_CNT_ZERO;
    wake_load = `CSC_WAKE_SHORT;
    case (sut_now)
      `CSC_SUT_MID:  wdt_load = `CSC_WDT_MID;
      `CSC_SUT_LONG: wdt_load = WDT_LONG_CYC;
      default:       wdt_load = `CSC_CNT_ZERO;
    endcase
    case (sel_q)
      `CSC_SEL_LF_FAST: wake_load = `CSC_WAKE_LF_FAST;
      `CSC_SEL_LF_SLOW: wake_load = LF_SLOW_WAKE_CYC;
      default:          wake_load = `CSC_WAKE_SHORT;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Start-up sequencer: watchdog delay, then 14 source cycles, then run.
  // A reserved start-up code or an unsupported source parks the sequencer in
  // the fault state until the next reset, with the CPU clock held.
  always @* begin
    state_d = state_q;
    case (state_q)
      ST_LOAD:  state_d = cfg_ok ? ST_WDT : ST_FAULT;
      ST_WDT:   if (wdt_done) state_d = ST_CK14;
      ST_CK14:  if (ck_done) state_d = ST_RUN;
      ST_RUN:   if (sleep_req) state_d = ST_SLEEP;
      ST_SLEEP: if (wake_i) state_d = ST_WAKE;
      ST_WAKE:  if (ck_done) state_d = ST_RUN;
      ST_FAULT: state_d = ST_FAULT;
      default:  state_d = ST_LOAD;
    endcase
  end

  // Counters load on entry to the phase they time.
  assign load_wdt = (state_d == ST_WDT) && (state_q != ST_WDT);
  assign load_ck  = ((state_d == ST_CK14) && (state_q != ST_CK14)) ||
                    ((state_d == ST_WAKE) && (state_q != ST_WAKE));
  assign ck_load  = (state_d == ST_WAKE) ? wake_load : `CSC_RESET_CK;

  // Real-time part counts on the watchdog oscillator whatever the source.
  csc_delay_counter u_wdt_delay (
    .clock_i      (clock_i),
    .rst_n_i      (rst_n_i),
    .load_i       (load_wdt),
    .load_value_i (wdt_load),
    .tick_i       (wdt_tick_i),
    .done_o       (wdt_done)
  );

  // Source-cycle part counts on the selected oscillator.
  csc_delay_counter u_ck_delay (
    .clock_i      (clock_i),
    .rst_n_i      (rst_n_i),
    .load_i       (load_ck),
    .load_value_i (ck_load),
    .tick_i       (src_tick),
    .done_o       (ck_done)
  );

  // Sequencer state, fuse latch at reset release and trim register.
  always @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_q <= ST_LOAD;
      sel_q   <= `CSC_SEL_RC;
      sut_q   <= `CSC_SUT_RSVD;
      trim_q  <= `CSC_TRIM_RST;
      fault_q <= 1'b0;
    end else begin
      state_q <= state_d;
      fault_q <= (state_d == ST_FAULT);
      if (state_q == ST_LOAD) begin
        sel_q  <= clock_source_select_fuses_i;
        sut_q  <= startup_time_fuses_i;
        trim_q <= calibration_byte_i;
      end else if (wr_take && (avs_address_i == `CSC_IDX_TRIM) && avs_byteenable_i[0]) begin
        trim_q <= avs_writedata_i[7:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Avalon slave: every access answers one cycle after it appears.
  assign bus_req           = avs_read_i || avs_write_i;
  assign avs_waitrequest_o = bus_req && !ack_q;
  assign wr_take           = avs_write_i && ack_q;
  assign sleep_req         = wr_take && (avs_address_i == `CSC_IDX_CTRL) &&
                             avs_byteenable_i[0] && avs_writedata_i[`CSC_CTRL_SLEEP_BIT];

  assign status_word = {16'h0000, rc_selected, (clock_output_fuse_i == `CSC_FUSE_PROG),
                        sut_q, sel_q, fault_q, state_q};

  // Acknowledge flag and read data capture.
  // A read captures its data in the wait cycle, so the data already stands
  // when waitrequest falls and the master takes it.
  always @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ack_q          <= 1'b0;
      avs_readdata_o <= 32'h00000000;
    end else begin
      ack_q <= bus_req && !ack_q;
      if (avs_read_i && !ack_q) begin
        case (avs_address_i)
          `CSC_IDX_TRIM:   avs_readdata_o <= {24'h000000, trim_q};
          `CSC_IDX_STATUS: avs_readdata_o <= status_word;
          default:         avs_readdata_o <= 32'h00000000;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Registered outputs to the clock tree and oscillators.
  assign rc_selected = (sel_now == `CSC_SEL_RC);

  // Every output here lags its source by one edge, so the oscillator sees a
  // new trim value one cycle after the bus write is taken.

  always @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cpu_clock_run_o       <= 1'b0;
      clock_source_o        <= `CSC_SRC_NONE;
      rc_trim_register_o    <= `CSC_TRIM_RST;
      trim_range_bit_o      <= 1'b0;
      trim_step_field_o     <= 7'h00;
      nvm_write_tick_o      <= 1'b0;
      timer_osc_enable_o    <= 1'b0;
      timer_osc_ext_clock_o <= 1'b0;
    end else begin
      cpu_clock_run_o       <= (state_d == ST_RUN);
      clock_source_o        <= src_code;
      rc_trim_register_o    <= trim_q;
      trim_range_bit_o      <= trim_q[7];
      trim_step_field_o     <= trim_q[6:0];
      nvm_write_tick_o      <= rc_tick_i;
      timer_osc_enable_o    <= rc_selected && timer_osc_request_i;
      timer_osc_ext_clock_o <= rc_selected && timer_osc_request_i &&
                               async_external_clock_select_i;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Divided system clock for the output pin, running also during start-up.
  // Only the block reset clears the divider, so the pin keeps toggling
  // through the watchdog and source-cycle phases of start-up.
  csc_clkout_divider u_clkout (
    .clock_i     (clock_i),
    .rst_n_i     (rst_n_i),
    .tick_i      (src_tick),
    .div_sel_i   (prescale_sel_i),
    .clk_level_o (clk_div_level)
  );

  // Programmed fuse overrides the pin's normal function.
  assign clock_output_pin_o      = (clock_output_fuse_i == `CSC_FUSE_PROG) ? clk_div_level : gpio_out_i;
  assign clock_output_pin_oe_n_o = (clock_output_fuse_i == `CSC_FUSE_PROG) ? 1'b0 : gpio_oe_n_i;

endmodule

// *** csc_clock_startup_ctrl_assertions.sv ***
// Concurrent checks on the ports of the clock source and start-up controller.
// Assumes one clock domain with an asynchronous active-low reset.
module csc_checker (
  // Clock, reset and inputs.
  input wire        clock_i,
  input wire        rst_n_i,
  input wire        clock_output_fuse_i,
  input wire        gpio_out_i,
  input wire        gpio_oe_n_i,
  input wire [1:0]  avs_address_i,
  input wire        avs_read_i,
  input wire        avs_write_i,
  input wire [31:0] avs_writedata_i,
  input wire [3:0]  avs_byteenable_i,
  input wire        rc_tick_i,
  input wire        timer_osc_request_i,
  // Outputs.
  input wire        avs_waitrequest_o,
  input wire        cpu_clock_run_o,
  input wire [1:0]  clock_source_o,
  input wire [7:0]  rc_trim_register_o,
  input wire        trim_range_bit_o,
  input wire [6:0]  trim_step_field_o,
  input wire        timer_osc_enable_o,
  input wire        timer_osc_ext_clock_o,
  input wire        nvm_write_tick_o,
  input wire        clock_output_pin_o,
  input wire        clock_output_pin_oe_n_o
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);
  // Low byte of the write data, kept apart so that its history can be taken.
  wire [7:0] wr_byte = avs_writedata_i[7:0];
  //////////////////////////////////////////////////////////////////////////////
  // Clock output pin ownership.
  property p_pin_owned; !clock_output_fuse_i |-> !clock_output_pin_oe_n_o; endproperty
  a_pin_owned: assert property (p_pin_owned) else $error("clock pin not driven");
  property p_pin_free;
    clock_output_fuse_i |-> clock_output_pin_o == gpio_out_i && clock_output_pin_oe_n_o == gpio_oe_n_i;
  endproperty
  a_pin_free: assert property (p_pin_free) else $error("pin not returned to normal use");
  // Timer oscillator only beside the RC source.
  property p_timer_rc; timer_osc_enable_o |-> clock_source_o != 2'h1 && clock_source_o != 2'h3; endproperty
  a_timer_rc: assert property (p_timer_rc) else $error("timer oscillator on a pin source");
  property p_timer_ext; timer_osc_ext_clock_o |-> timer_osc_enable_o; endproperty
  a_timer_ext: assert property (p_timer_ext) else $error("external timer clock without timer");
  property p_timer_on; clock_source_o == 2'h2 && $past(timer_osc_request_i) |-> timer_osc_enable_o; endproperty
  a_timer_on: assert property (p_timer_on) else $error("timer oscillator not enabled");
  // Memory write timing follows the RC oscillator one edge later.
  property p_nvm_tick; $past(rst_n_i) |-> nvm_write_tick_o == $past(rc_tick_i); endproperty
  a_nvm_tick: assert property (p_nvm_tick) else $error("memory write tick not from the RC oscillator");
  // Trim fields follow the trim value.
  property p_trim_split; {trim_range_bit_o, trim_step_field_o} == rc_trim_register_o; endproperty
  a_trim_split: assert property (p_trim_split) else $error("trim fields disagree");
  // The CPU clock only runs with a source chosen.
  property p_run_src; cpu_clock_run_o |-> clock_source_o != 2'h0; endproperty
  a_run_src: assert property (p_run_src) else $error("run without a source");
  // Bus answers after exactly one wait cycle.
  property p_one_wait; $rose(avs_read_i || avs_write_i) |-> avs_waitrequest_o ##1 !avs_waitrequest_o; endproperty
  a_one_wait: assert property (p_one_wait) else $error("bus wait not one cycle");
  // An accepted trim write reaches the trim output two edges on.
  property p_trim_write;
    avs_write_i && !avs_waitrequest_o && avs_address_i == 2'h0 && avs_byteenable_i[0]
      |-> ##2 rc_trim_register_o == $past(wr_byte, 2);
  endproperty
  a_trim_write: assert property (p_trim_write) else $error("trim write lost");
endmodule

bind csc_clock_startup_ctrl csc_checker u_chk (
  .clock_i(clock_i), .rst_n_i(rst_n_i), .clock_output_fuse_i(clock_output_fuse_i),
  .gpio_out_i(gpio_out_i), .gpio_oe_n_i(gpio_oe_n_i), .avs_address_i(avs_address_i),
  .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
  .avs_byteenable_i(avs_byteenable_i), .avs_waitrequest_o(avs_waitrequest_o),
  .rc_tick_i(rc_tick_i), .timer_osc_request_i(timer_osc_request_i), .nvm_write_tick_o(nvm_write_tick_o),
  .cpu_clock_run_o(cpu_clock_run_o), .clock_source_o(clock_source_o),
  .rc_trim_register_o(rc_trim_register_o), .trim_range_bit_o(trim_range_bit_o),
  .trim_step_field_o(trim_step_field_o), .timer_osc_enable_o(timer_osc_enable_o),
  .timer_osc_ext_clock_o(timer_osc_ext_clock_o), .clock_output_pin_o(clock_output_pin_o),
  .clock_output_pin_oe_n_o(clock_output_pin_oe_n_o));

// *** csc_clock_startup_ctrl_test.sv ***
// Self-checking bench for the clock source and start-up controller.
// Assumes the oscillator model and the bound checker beside the design.
module csc_clock_startup_ctrl_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock_i = 0, rst_n_i = 0, fuse_q = 1, wake_q = 0, treq_q = 0, tasync_q = 0, gout_q = 0, goe_q = 1;
  logic rd_q = 0, wr_q = 0, flt;
  logic [3:0] sel_q = 0, psc_q = 0, be_q = 4'hF;
  logic [1:0] sut_q = 0, adr_q = 0;
  logic [7:0] cal_q = 0, t;
  logic [31:0] wd_q = 0, q;
  logic [5:0] cfg [7] = '{6'h08, 6'h01, 6'h1A, 6'h1C, 6'h02, 6'h0B, 6'h14};
  wire [31:0] rdata;
  wire [1:0] src_w;
  wire [7:0] trim_w;
  wire wait_w, run_w, pin_w, lf_t, rc_t, ext_t, wdt_t;
  wire src_t = sel_q == 4'h0 ? ext_t : sel_q == 4'h2 ? rc_t : lf_t;
  int err_total = 0, n_checks = 0, s;
  //////////////////////////////////////////////////////////////////////////////
  // Clock, oscillators and design.
  always #5 clock_i = ~clock_i;
  csc_osc_model osc (.clock_i(clock_i), .lf_tick_o(lf_t), .rc_tick_o(rc_t), .ext_tick_o(ext_t), .wdt_tick_o(wdt_t));
  csc_clock_startup_ctrl #(.WDT_LONG_CYC(17'h00040), .LF_SLOW_WAKE_CYC(17'h00020)) dut (
    .clock_i(clock_i), .rst_n_i(rst_n_i), .clock_source_select_fuses_i(sel_q), .startup_time_fuses_i(sut_q),
    .clock_output_fuse_i(fuse_q), .calibration_byte_i(cal_q), .lf_tick_i(lf_t), .rc_tick_i(rc_t),
    .ext_tick_i(ext_t), .wdt_tick_i(wdt_t), .wake_i(wake_q), .prescale_sel_i(psc_q),
    .timer_osc_request_i(treq_q), .async_external_clock_select_i(tasync_q), .gpio_out_i(gout_q),
    .gpio_oe_n_i(goe_q), .avs_address_i(adr_q), .avs_read_i(rd_q), .avs_write_i(wr_q),
    .avs_writedata_i(wd_q), .avs_byteenable_i(be_q), .avs_readdata_o(rdata), .avs_waitrequest_o(wait_w),
    .cpu_clock_run_o(run_w), .clock_source_o(src_w), .rc_trim_register_o(trim_w), .trim_range_bit_o(),
    .trim_step_field_o(), .nvm_write_tick_o(), .timer_osc_enable_o(), .timer_osc_ext_clock_o(),
    .clock_output_pin_o(pin_w), .clock_output_pin_oe_n_o());
  //////////////////////////////////////////////////////////////////////////////
  // Expected figures per fuse setting.
  function automatic int exp_wdt(input logic [1:0] startup_time_fuses);
    return startup_time_fuses == 2'h1 ? 4096 : startup_time_fuses == 2'h2 ? 64 : 0;
  endfunction
  function automatic logic [1:0] exp_src(input logic [3:0] sel);
    return sel == 4'h0 ? 2'h3 : sel == 4'h2 ? 2'h2 : 2'h1;
  endfunction
  function automatic int exp_wake(input logic [3:0] sel);
    return sel == 4'h6 ? 1024 : sel == 4'h7 ? 32 : 6;
  endfunction
  // Comparison, verdict and bus tasks.
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      err_total++;
    end
  endtask
  task automatic complete_run();
    if (err_total == 0 && n_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic bus(input logic w, input logic [1:0] a, input logic [31:0] d, input logic [3:0] be,
                     output logic [31:0] r);
    int i;
    @(posedge clock_i);
    rd_q <= !w; wr_q <= w; adr_q <= a; wd_q <= d; be_q <= be;
    for (i = 0; i < 20; i++) begin
      @(posedge clock_i);
      if (wait_w === 1'b0) break;
    end
    if (i == 20) begin err_total++; complete_run(); end
    r = rdata;
    rd_q <= 1'b0; wr_q <= 1'b0;
  endtask
  // Counts source ticks after ew watchdog ticks until the CPU clock runs.
  task automatic wait_run(input int ew, output int n);
    int w, i;
    w = 0; n = 0;
    for (i = 0; i < 20000 && run_w !== 1'b1; i++) begin
      @(posedge clock_i);
      if (w >= ew && src_t === 1'b1) n++;
      if (wdt_t === 1'b1) w++;
    end
    if (run_w !== 1'b1) begin err_total++; complete_run(); end
  endtask
  // Counts source ticks over one full period of the clock output pin.
  task automatic pin_period(output int n);
    int i, r;
    logic p;
    n = 0; r = 0; p = pin_w;
    for (i = 0; i < 4000 && r < 2; i++) begin
      @(posedge clock_i);
      if (r == 1 && src_t === 1'b1) n++;
      if (pin_w === 1'b1 && p === 1'b0) r++;
      p = pin_w;
    end
  endtask
  //////////////////////////////////////////////////////////////////////////////
  // Seven fuse settings: reset and start-up, then trim access, clock pin, sleep and wake where no fault.
  initial begin
    void'($urandom(32'h40C8D6D2));
    foreach (cfg[k]) begin
      @(posedge clock_i);
      rst_n_i <= 1'b0; {sel_q, sut_q} <= cfg[k]; fuse_q <= k[0]; cal_q <= 8'($urandom);
      psc_q <= 4'($urandom_range(2)); treq_q <= (k == 0) | 1'($urandom); tasync_q <= (k == 0) | 1'($urandom);
      gout_q <= 1'($urandom); goe_q <= 1'($urandom);
      repeat (5) @(posedge clock_i);
      rst_n_i <= 1'b1;
      flt = cfg[k][1:0] == 2'h3 || !(cfg[k][5:2] inside {4'h0, 4'h2, 4'h6, 4'h7});
      if (flt) repeat (3000) @(posedge clock_i);
      else wait_run(exp_wdt(cfg[k][1:0]), s);
      check("run", run_w, !flt);
      check("trim", trim_w, cal_q);
      if (!flt) begin
        check("source", src_w, exp_src(sel_q));
        check("startup", s inside {[14:15]}, 1);
        // Random trims are fine because nothing writes memory here.
        t = 8'($urandom);
        bus(1'b1, 2'h0, t, 4'hF, q);
        bus(1'b1, 2'h0, ~t, 4'hE, q);
        bus(1'b0, 2'h0, 0, 4'hF, q);
        check("trim_read", q, t);
        bus(1'b0, 2'h3, 32'hFFFFFFFF, 4'hF, q);
        check("unmapped", q, 0);
        bus(1'b0, 2'h1, 0, 4'hF, q);
        check("status", q, {16'h0000, sel_q == 4'h2, !fuse_q, sut_q, sel_q, 8'h08});
        if (!fuse_q) begin
          pin_period(s);
          check("pin_period", s, 2 << psc_q);
        end
        bus(1'b1, 2'h2, 1, 4'hF, q);
        repeat (3) @(posedge clock_i);
        check("asleep", run_w, 0);
        wake_q <= 1'b1;
        wait_run(0, s);
        wake_q <= 1'b0;
        check("wake", s inside {[exp_wake(sel_q) - 1 : exp_wake(sel_q) + 2]}, 1);
      end
    end
    complete_run();
  end
endmodule

// *** csc_defs.vh ***
// Constants shared by the clock source and start-up controller.
// Assumes inclusion by bare name from every design file of the block.
`ifndef CSC_DEFS_VH
`define CSC_DEFS_VH

////////////////////////////////////////////////////////////////////////////////
// Source select fuse codes, a programmed fuse reads as zero.
`define CSC_SEL_EXT        4'h0
`define CSC_SEL_RC         4'h2
`define CSC_SEL_LF_FAST    4'h6
`define CSC_SEL_LF_SLOW    4'h7

// Start-up time fuse codes.
`define CSC_SUT_SHORT      2'h0
`define CSC_SUT_MID        2'h1
`define CSC_SUT_LONG       2'h2
`define CSC_SUT_RSVD       2'h3

// Programmed state of a single fuse bit.
`define CSC_FUSE_PROG      1'h0

////////////////////////////////////////////////////////////////////////////////
// Cycle counts, all 17 bits wide to match the delay counters.
`define CSC_CNT_W          17
`define CSC_CNT_ZERO       17'h00000
`define CSC_RESET_CK       17'h0000E
`define CSC_WDT_MID        17'h01000
`define CSC_WAKE_SHORT     17'h00006
`define CSC_WAKE_LF_FAST   17'h00400

////////////////////////////////////////////////////////////////////////////////
// Clock source codes reported to the clock tree.
`define CSC_SRC_NONE       2'h0
`define CSC_SRC_LF         2'h1
`define CSC_SRC_RC         2'h2
`define CSC_SRC_EXT        2'h3

////////////////////////////////////////////////////////////////////////////////
// Register word indices on the bus, byte offset is four times the index.
`define CSC_IDX_TRIM       2'h0
`define CSC_IDX_STATUS     2'h1
`define CSC_IDX_CTRL       2'h2

// Field positions, reset values and clock output divider limits.
`define CSC_TRIM_RST       8'h00
`define CSC_CTRL_SLEEP_BIT 0
`define CSC_DIV_MAX        4'h8
`define CSC_MASK_FULL      8'hFF

`endif

// *** csc_delay_counter.v ***
// Down counter that times one start-up phase in ticks of a slow clock.
// Assumes the tick input is a one-cycle pulse synchronous to clock_i.
`include "csc_defs.vh"

module csc_delay_counter (
  // Clock and reset.
  input  wire                     clock_i,
  input  wire                     rst_n_i,
  // Control.
  input  wire                     load_i,
  input  wire [`CSC_CNT_W-1:0]    load_value_i,
  input  wire                     tick_i,
  // Status.
  output wire                     done_o
);

  reg [`CSC_CNT_W-1:0] cnt_q;

  // Load wins over a tick, otherwise count each tick down to zero.
  always @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_q <= `CSC_CNT_ZERO;
    end else if (load_i) begin
      cnt_q <= load_value_i;
    end else if (tick_i && (cnt_q != `CSC_CNT_ZERO)) begin
      cnt_q <= cnt_q - 1'b1;
    end
  end

  // The phase has elapsed once the count is exhausted.
  assign done_o = (cnt_q == `CSC_CNT_ZERO) && !load_i;

endmodule

// *** csc_osc_model.sv ***
// Free-running oscillators that give one tick pulse per source cycle.
// Assumes ticks are sampled on the rising edge of clock_i.
module csc_osc_model (
  // Clock.
  input  wire  clock_i,
  // Tick pulses.
  output logic lf_tick_o,
  output logic rc_tick_o,
  output logic ext_tick_o,
  output logic wdt_tick_o
);
  timeunit 1ns;
  timeprecision 1ns;
  int unsigned n_q = 0;
  initial {lf_tick_o, rc_tick_o, ext_tick_o, wdt_tick_o} = 4'h0;
  // Fixed periods keep the external clock steady from cycle to cycle.
  always @(posedge clock_i) begin
    n_q <= n_q + 1;
    lf_tick_o <= (n_q % 4) == 0;
    rc_tick_o <= (n_q % 3) == 0;
    ext_tick_o <= (n_q % 5) == 0;
    wdt_tick_o <= (n_q % 2) == 0;
  end
endmodule
